/* File: psp_map.svh */
// Timing counts and code constants for the power stage protection block
`ifndef PSP_MAP_SVH
`define PSP_MAP_SVH
`define PSP_CLK_MHZ        250
`define PSP_BLANK_NCP_NS   100
`define PSP_BLANK_HSD_NS   65
`define PSP_BLANK_NCP_CYC  ((`PSP_BLANK_NCP_NS * `PSP_CLK_MHZ + 999) / 1000)
`define PSP_BLANK_HSD_CYC  ((`PSP_BLANK_HSD_NS * `PSP_CLK_MHZ + 999) / 1000)
`define PSP_TRI_REL_NS     2000
`define PSP_TRI_REL_CYC    ((`PSP_TRI_REL_NS * `PSP_CLK_MHZ + 999) / 1000)
`define PSP_OC_SETUP_US    120
`define PSP_OC_SETUP_CYC   (`PSP_OC_SETUP_US * `PSP_CLK_MHZ)
`define PSP_OC_COUNT       9
`define PSP_OC_REL_COUNT   3
`define PSP_TRI_HOLD_CYC   16
`define PSP_LIM_120A       2'h0
`define PSP_LIM_100A       2'h1
`define PSP_LIM_85A        2'h2
`endif

/* File: psp_pkg.sv */
// Types for the power stage protection block
package psp_pkg;
  typedef enum logic [1:0]
  {
    PSP_FLAG_TEMP = 2'h0,
    PSP_FLAG_HIGH = 2'h1,
    PSP_FLAG_LOW  = 2'h2
  } psp_flag_t;
  typedef enum logic [1:0]
  {
    PSP_PWM_LOW  = 2'h0,
    PSP_PWM_HIGH = 2'h1,
    PSP_PWM_TRI  = 2'h2
  } psp_pwm_t;
endpackage

/* File: psp_protect.sv */
// Protection and fault logic of a half-bridge power stage
// What this block does
// - Output above 2.8V forces low side on
// - Pre-overvoltage guard works enabled or disabled
// - Supply lockout drives fault flag low
// - Overcurrent, overtemp, short drive flag high
// - Flag overcurrent after nine consecutive peaks
// - Limit pin selects 120A, 100A or 85A
// - Overcurrent release: lockout, three low, tri-state
// - Zero current turns low side off
// - Zero current detect only with pin open/high
// - Negative current uses valley, 100ns blanking
// - Switch node high: short, flag, freeze gates
// - Short clears only on supply lockout
// - Overtemperature: gates off, flag high, hysteresis
// - Power input lockout: all off, flag low
// - Driver lockout: off, flag low, monitor ref
// - Enable low holds both gates off unless pre-overvoltage holds low side on or a latched short freezes them
// - Held tri-state turns both gates off
// - Below -60A turns low side off while zero current detect is off
// - Latch limit selection first 120us after enable
`timescale 1ns/1ps
`include "psp_map.svh"
module psp_protect #(
  parameter int unsigned OC_SETUP_CYC = `PSP_OC_SETUP_CYC,
  parameter int unsigned TRI_HOLD_CYC = `PSP_TRI_HOLD_CYC
)(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // Controller inputs
  input  wire logic       enable_in,
  input  wire logic       pwm_high_in,
  input  wire logic       pwm_tri_in,
  // Limit select pin decode: open/high, mid resistor, low resistor
  input  wire logic       limit_pin_open,
  input  wire logic       limit_pin_mid,
  // Comparator flags
  input  wire logic       vout_above_hi,
  input  wire logic       vout_above_lo,
  input  wire logic       power_input_undervolt,
  input  wire logic       power_input_above_hi,
  input  wire logic       driver_supply_undervolt,
  input  wire logic       driver_supply_above_hi,
  input  wire logic       temp_above_hi,
  input  wire logic       temp_above_lo,
  input  wire logic       peak_over_limit,
  input  wire logic       peak_below_release,
  input  wire logic       valley_below_zero,
  input  wire logic       valley_below_neg_hi,
  input  wire logic       valley_below_neg_lo,
  input  wire logic       switch_node_high,
  // Gate drives
  output logic            high_side_gate,
  output logic            low_side_gate,
  // Monitors and fault flag
  output logic            current_monitor_en,
  output logic            current_monitor_ref,
  output logic            temperature_sense_en,
  output psp_pkg::psp_flag_t fault_temp_flag_out,
  // Status
  output logic [1:0]      limit_select,
  output logic            zero_current_detect_en,
  output logic            overcurrent_protect,
  output logic            high_side_short_detect,
  output logic            output_preovervolt_protect,
  output logic            overtemp_fault,
  output logic            power_input_lockout,
  output logic            driver_supply_lockout
);

  initial
  begin
    if (OC_SETUP_CYC < 1 || TRI_HOLD_CYC < 1)
      $error("psp_protect: counts must be at least one");
  end

  localparam int NS = 18;

  logic [NS-1:0] raw_in;
  logic [NS-1:0] sy1_ff;
  logic [NS-1:0] sy2_ff;
  assign raw_in = {enable_in, pwm_high_in, pwm_tri_in, limit_pin_open, limit_pin_mid,
                   vout_above_hi, vout_above_lo, power_input_undervolt,
                   power_input_above_hi, driver_supply_undervolt, driver_supply_above_hi,
                   temp_above_hi, temp_above_lo, peak_over_limit, peak_below_release,
                   valley_below_zero, valley_below_neg_hi, switch_node_high};
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sy1_ff <= '0;
      sy2_ff <= '0;
    end
    else
    begin
      sy1_ff <= raw_in;
      sy2_ff <= sy1_ff;
    end
  end

  logic neg_lo_s1_ff;
  logic neg_lo_ff;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      neg_lo_s1_ff <= 1'b0;
      neg_lo_ff    <= 1'b0;
    end
    else
    begin
      neg_lo_s1_ff <= valley_below_neg_lo;
      neg_lo_ff    <= neg_lo_s1_ff;
    end
  end

  logic en_s, pwm_h, pwm_t, pin_open, pin_mid, vo_hi, vo_lo, pi_uv, pi_ok, ds_uv, ds_ok;
  logic t_hi, t_lo, pk_ov, pk_rel, vz, vn_hi, sw_hi;
  assign {en_s, pwm_h, pwm_t, pin_open, pin_mid, vo_hi, vo_lo, pi_uv, pi_ok, ds_uv, ds_ok,
          t_hi, t_lo, pk_ov, pk_rel, vz, vn_hi, sw_hi} = sy2_ff;

  // Supply lockouts with hysteresis
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      power_input_lockout   <= 1'b1;
      driver_supply_lockout <= 1'b1;
    end
    else
    begin
      if (pi_uv)
        power_input_lockout <= 1'b1;
      else if (pi_ok)
        power_input_lockout <= 1'b0;
      if (ds_uv)
        driver_supply_lockout <= 1'b1;
      else if (ds_ok)
        driver_supply_lockout <= 1'b0;
    end
  end
  logic lockout;
  assign lockout = power_input_lockout | driver_supply_lockout;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      output_preovervolt_protect <= 1'b0;
    else if (vo_hi)
      output_preovervolt_protect <= 1'b1;
    else if (!vo_lo)
      output_preovervolt_protect <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      overtemp_fault <= 1'b0;
    else if (t_hi)
      overtemp_fault <= 1'b1;
    else if (!t_lo)
      overtemp_fault <= 1'b0;
  end

  logic [$clog2(OC_SETUP_CYC+1)-1:0] setup_cnt_ff;
  logic en_d_ff;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      setup_cnt_ff <= '0;
      en_d_ff      <= 1'b0;
      limit_select <= `PSP_LIM_120A;
    end
    else
    begin
      en_d_ff <= en_s;
      if (en_s && !en_d_ff)
        setup_cnt_ff <= '0;
      else if (en_s && setup_cnt_ff < OC_SETUP_CYC[$bits(setup_cnt_ff)-1:0])
      begin
        setup_cnt_ff <= setup_cnt_ff + 1'b1;
        limit_select <= pin_open ? `PSP_LIM_120A : (pin_mid ? `PSP_LIM_100A : `PSP_LIM_85A);
      end
    end
  end

  assign zero_current_detect_en = pin_open;

  logic [$clog2(`PSP_TRI_REL_CYC+TRI_HOLD_CYC+1)-1:0] tri_cnt_ff;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      tri_cnt_ff <= '0;
    else if (!pwm_t)
      tri_cnt_ff <= '0;
    else if (tri_cnt_ff != '1)
      tri_cnt_ff <= tri_cnt_ff + 1'b1;
  end
  logic tri_off, tri_rel;
  assign tri_off = pwm_t && tri_cnt_ff >= TRI_HOLD_CYC;
  assign tri_rel = pwm_t && tri_cnt_ff >= `PSP_TRI_REL_CYC;

  // Low side on-time counter for blanking; valley sensing
  logic [7:0] ls_cnt_ff;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      ls_cnt_ff <= '0;
    else if (!low_side_gate)
      ls_cnt_ff <= '0;
    else if (ls_cnt_ff != 8'hff)
      ls_cnt_ff <= ls_cnt_ff + 8'h01;
  end
  logic ncp_blank_done, hsd_blank_done;
  assign ncp_blank_done = ls_cnt_ff >= 8'(`PSP_BLANK_NCP_CYC);
  assign hsd_blank_done = ls_cnt_ff >= 8'(`PSP_BLANK_HSD_CYC);

  // Zero-current and negative-current low side cutoff
  logic zcd_off_ff, ncp_off_ff, pwm_h_d_ff;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      zcd_off_ff <= 1'b0;
      ncp_off_ff <= 1'b0;
      pwm_h_d_ff <= 1'b0;
    end
    else
    begin
      pwm_h_d_ff <= pwm_h;
      if (pwm_h && !pwm_h_d_ff)
        zcd_off_ff <= 1'b0;
      else if (zero_current_detect_en && low_side_gate && ncp_blank_done && vz)
        zcd_off_ff <= 1'b1;
      if (zero_current_detect_en)
        ncp_off_ff <= 1'b0;
      else if (low_side_gate && ncp_blank_done && vn_hi)
        ncp_off_ff <= 1'b1;
      else if (!neg_lo_ff)
        ncp_off_ff <= 1'b0;
    end
  end

  // Overcurrent counting and release
  logic [3:0] oc_cnt_ff;
  logic [1:0] rel_cnt_ff;
  logic       pwm_h_oc_ff;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      oc_cnt_ff           <= '0;
      rel_cnt_ff          <= '0;
      pwm_h_oc_ff         <= 1'b0;
      overcurrent_protect <= 1'b0;
    end
    else
    begin
      pwm_h_oc_ff <= pwm_h;
      if (lockout || tri_rel)
      begin
        oc_cnt_ff           <= '0;
        rel_cnt_ff          <= '0;
        overcurrent_protect <= 1'b0;
      end
      else if (!pwm_h && pwm_h_oc_ff)
      begin
        if (pk_ov)
        begin
          rel_cnt_ff <= '0;
          if (oc_cnt_ff == 4'(`PSP_OC_COUNT - 1))
            overcurrent_protect <= 1'b1;
          else
            oc_cnt_ff <= oc_cnt_ff + 4'h1;
        end
        else
        begin
          oc_cnt_ff <= '0;
          if (pk_rel && overcurrent_protect)
          begin
            if (rel_cnt_ff == 2'(`PSP_OC_REL_COUNT - 1))
            begin
              overcurrent_protect <= 1'b0;
              rel_cnt_ff          <= '0;
            end
            else
              rel_cnt_ff <= rel_cnt_ff + 2'h1;
          end
          else
            rel_cnt_ff <= '0;
        end
      end
    end
  end

  // short latch cleared by lockout only
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      high_side_short_detect <= 1'b0;
    else if (lockout)
      high_side_short_detect <= 1'b0;
    else if (low_side_gate && hsd_blank_done && sw_hi)
      high_side_short_detect <= 1'b1;
  end

  // Gate decision, priority from top
  logic nxt_hs, nxt_ls;
  always_comb
  begin
    nxt_hs = 1'b0;
    nxt_ls = 1'b0;
    if (lockout)
    begin
      nxt_hs = 1'b0;
      nxt_ls = 1'b0;
    end
    else if (high_side_short_detect)
    begin
      nxt_hs = high_side_gate;
      nxt_ls = low_side_gate;
    end
    else if (output_preovervolt_protect)
      nxt_ls = 1'b1;
    else if (overtemp_fault || !en_s || tri_off)
    begin
      nxt_hs = 1'b0;
      nxt_ls = 1'b0;
    end
    else if (pwm_t)
    begin
      nxt_hs = high_side_gate;
      nxt_ls = low_side_gate;
    end
    else
    begin
      nxt_hs = pwm_h;
      nxt_ls = !pwm_h && !zcd_off_ff && !ncp_off_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      high_side_gate <= 1'b0;
      low_side_gate  <= 1'b0;
    end
    else
    begin
      high_side_gate <= nxt_hs;
      low_side_gate  <= nxt_ls;
    end
  end

  // Fault flag and monitors
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      fault_temp_flag_out  <= psp_pkg::PSP_FLAG_LOW;
      current_monitor_en   <= 1'b0;
      current_monitor_ref  <= 1'b1;
      temperature_sense_en <= 1'b0;
    end
    else
    begin
      current_monitor_en   <= !lockout;
      temperature_sense_en <= !lockout;
      current_monitor_ref  <= driver_supply_lockout;
      if (lockout)
        fault_temp_flag_out <= psp_pkg::PSP_FLAG_LOW;
      else if (overcurrent_protect || overtemp_fault || high_side_short_detect)
        fault_temp_flag_out <= psp_pkg::PSP_FLAG_HIGH;
      else
        fault_temp_flag_out <= psp_pkg::PSP_FLAG_TEMP;
    end
  end

endmodule

/* File: psp_chk.sv */
// Assertion checker for the power stage protection block
`timescale 1ns/1ps
module psp_chk (
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               rstn,
  // Watched ports
  input wire logic               enable_in,
  input wire logic               high_side_gate,
  input wire logic               low_side_gate,
  input wire logic               current_monitor_en,
  input wire logic               current_monitor_ref,
  input wire psp_pkg::psp_flag_t fault_temp_flag_out,
  input wire logic               overcurrent_protect,
  input wire logic               high_side_short_detect,
  input wire logic               output_preovervolt_protect,
  input wire logic               overtemp_fault,
  input wire logic               power_input_lockout,
  input wire logic               driver_supply_lockout
);
  logic lk;
  logic hf;
  assign lk = power_input_lockout | driver_supply_lockout;
  assign hf = overcurrent_protect | overtemp_fault | high_side_short_detect;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_lock_flag_low:
    assert property (lk[*2] |-> fault_temp_flag_out == psp_pkg::PSP_FLAG_LOW)
    else $error("flag not low in lockout");
  a_lock_gates_off:
    assert property (lk[*2] |-> !high_side_gate && !low_side_gate)
    else $error("gate on in lockout");
  a_drv_ref_tie:
    assert property (driver_supply_lockout[*2] |-> current_monitor_ref && !current_monitor_en)
    else $error("monitor not tied in driver lockout");
  a_fault_flag_high:
    assert property ((hf && !lk)[*2] |-> fault_temp_flag_out == psp_pkg::PSP_FLAG_HIGH)
    else $error("flag not high on fault");
  a_short_sticky:
    assert property ($fell(high_side_short_detect) |-> lk)
    else $error("short cleared without lockout");
  a_short_freeze:
    assert property ((high_side_short_detect && !lk)[*3] |->
      $stable(high_side_gate) && $stable(low_side_gate))
    else $error("gates moved during short");
  a_output_preovervolt_protect_ls_on:
    assert property ((output_preovervolt_protect && !high_side_short_detect && !lk)[*2]
      |-> low_side_gate)
    else $error("low side off in preovervolt");
  a_disable_off:
    assert property ((!enable_in && !output_preovervolt_protect && !high_side_short_detect)[*5]
      |-> !high_side_gate && !low_side_gate)
    else $error("gate on while disabled");
  cover property ($rose(high_side_short_detect));
  cover property ($rose(overcurrent_protect));
  cover property ($rose(output_preovervolt_protect));
endmodule

/* File: psp_ctrl.sv */
// Behavioural model of the controller driving enable and PWM
`timescale 1ns/1ps
module psp_ctrl (
  // Clock
  input wire logic clk_sys,
  // Requests from the bench
  input wire logic en_req,
  input wire logic duty_hi,
  input wire logic tri_req,
  // Lines towards the stage
  output logic     enable_in,
  output logic     pwm_high_in,
  output logic     pwm_tri_in
);
  initial {enable_in, pwm_high_in, pwm_tri_in} = 3'h0;
  // Released line shows no steady level in tri-state
  always @(negedge clk_sys)
  begin
    enable_in   <= en_req;
    pwm_tri_in  <= tri_req;
    pwm_high_in <= tri_req ? ~pwm_high_in : duty_hi;
  end
endmodule

/* File: tb_top.sv */
// Self-checking testbench of the power stage protection block
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'h0, rstn = 1'h0, en_req = 1'h0, duty_hi = 1'h0, tri_req = 1'h0;
  logic enable_in, pwm_high_in, pwm_tri_in;
  logic limit_pin_open = 1'h0, limit_pin_mid = 1'h1;
  logic vout_above_hi = 1'h0, vout_above_lo = 1'h0;
  logic power_input_undervolt = 1'h1, power_input_above_hi = 1'h0;
  logic driver_supply_undervolt = 1'h1, driver_supply_above_hi = 1'h0;
  logic temp_above_hi = 1'h0, temp_above_lo = 1'h0;
  logic peak_over_limit = 1'h0, peak_below_release = 1'h0, switch_node_high = 1'h0;
  logic valley_below_zero = 1'h0, valley_below_neg_hi = 1'h0, valley_below_neg_lo = 1'h0;
  logic high_side_gate, low_side_gate, current_monitor_en, current_monitor_ref;
  logic temperature_sense_en, zero_current_detect_en, overcurrent_protect;
  logic high_side_short_detect, output_preovervolt_protect, overtemp_fault;
  logic power_input_lockout, driver_supply_lockout;
  logic [1:0] limit_select;
  psp_pkg::psp_flag_t fault_temp_flag_out;
  int error_cnt = 0, num_checks = 0;

  psp_protect #(.OC_SETUP_CYC(50), .TRI_HOLD_CYC(16)) dut (.*);
  psp_ctrl u_ctrl (.*);

  always #2 clk_sys = ~clk_sys;

  task automatic w(int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic chk(string n, logic [1:0] g, logic [1:0] e);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic pulse();
    duty_hi <= 1'h1;
    w(8);
    duty_hi <= 1'h0;
    w(8);
  endtask

  task automatic t_lockout();
    chk("flag", fault_temp_flag_out, psp_pkg::PSP_FLAG_LOW);
    chk("ref", current_monitor_ref, 1'h1);
    power_input_undervolt <= 1'h0;
    w(8);
    chk("vin_lock", power_input_lockout, 1'h1);
    power_input_above_hi <= 1'h1;
    w(8);
    chk("vin_lock", power_input_lockout, 1'h0);
    chk("mon_en", current_monitor_en, 1'h0);
    chk("temperature_sense_en", temperature_sense_en, 1'h0);
    driver_supply_undervolt <= 1'h0;
    driver_supply_above_hi <= 1'h1;
    w(8);
    chk("flag", fault_temp_flag_out, psp_pkg::PSP_FLAG_TEMP);
    chk("mon_en", current_monitor_en, 1'h1);
    chk("temperature_sense_en", temperature_sense_en, 1'h1);
    $display("lockout test done");
  endtask

  task automatic t_pwm();
    en_req <= 1'h1;
    duty_hi <= 1'h1;
    w(8);
    chk("hs", high_side_gate, 1'h1);
    chk("zcd", zero_current_detect_en, 1'h0);
    w(60);
    chk("limit", limit_select, 2'h1);
    limit_pin_mid <= 1'h0;
    limit_pin_open <= 1'h1;
    w(8);
    chk("limit", limit_select, 2'h1);
    chk("zcd", zero_current_detect_en, 1'h1);
    tri_req <= 1'h1;
    w(6);
    chk("hs", high_side_gate, 1'h1);
    w(24);
    chk("hs_ls", {high_side_gate, low_side_gate}, 2'h0);
    tri_req <= 1'h0;
    w(6);
    chk("hs", high_side_gate, 1'h1);
    duty_hi <= 1'h0;
    w(8);
    chk("ls", low_side_gate, 1'h1);
    en_req <= 1'h0;
    w(8);
    chk("hs_ls", {high_side_gate, low_side_gate}, 2'h0);
    $display("pwm test done");
  endtask

  task automatic t_output_preovervolt_protect();
    vout_above_hi <= 1'h1;
    vout_above_lo <= 1'h1;
    w(8);
    chk("ls", low_side_gate, 1'h1);
    vout_above_hi <= 1'h0;
    w(8);
    chk("ls", low_side_gate, 1'h1);
    vout_above_lo <= 1'h0;
    w(8);
    chk("ls", low_side_gate, 1'h0);
    $display("preovervolt test done");
  endtask

  task automatic t_otp();
    en_req <= 1'h1;
    duty_hi <= 1'h1;
    temp_above_hi <= 1'h1;
    temp_above_lo <= 1'h1;
    w(10);
    chk("hs_ls", {high_side_gate, low_side_gate}, 2'h0);
    chk("flag", fault_temp_flag_out, psp_pkg::PSP_FLAG_HIGH);
    temp_above_hi <= 1'h0;
    w(8);
    chk("otp", overtemp_fault, 1'h1);
    temp_above_lo <= 1'h0;
    w(8);
    chk("hs", high_side_gate, 1'h1);
    $display("overtemp test done");
  endtask

  task automatic t_oc();
    peak_over_limit <= 1'h1;
    repeat (8) pulse();
    chk("oc", overcurrent_protect, 1'h0);
    pulse();
    chk("oc", overcurrent_protect, 1'h1);
    chk("flag", fault_temp_flag_out, psp_pkg::PSP_FLAG_HIGH);
    peak_over_limit <= 1'h0;
    peak_below_release <= 1'h1;
    repeat (2) pulse();
    chk("oc", overcurrent_protect, 1'h1);
    pulse();
    chk("oc", overcurrent_protect, 1'h0);
    peak_below_release <= 1'h0;
    peak_over_limit <= 1'h1;
    repeat (9) pulse();
    chk("oc", overcurrent_protect, 1'h1);
    peak_over_limit <= 1'h0;
    tri_req <= 1'h1;
    w(450);
    chk("oc", overcurrent_protect, 1'h1);
    w(60);
    chk("oc", overcurrent_protect, 1'h0);
    tri_req <= 1'h0;
    w(8);
    chk("ls", low_side_gate, 1'h1);
    $display("overcurrent test done");
  endtask

  task automatic t_zcd();
    valley_below_zero <= 1'h1;
    w(30);
    chk("ls", low_side_gate, 1'h0);
    valley_below_zero <= 1'h0;
    w(8);
    chk("ls", low_side_gate, 1'h0);
    pulse();
    chk("ls", low_side_gate, 1'h1);
    $display("zero current test done");
  endtask

  task automatic t_ncp();
    limit_pin_open <= 1'h0;
    limit_pin_mid <= 1'h1;
    valley_below_neg_hi <= 1'h1;
    valley_below_neg_lo <= 1'h1;
    w(30);
    chk("zcd", zero_current_detect_en, 1'h0);
    chk("ls", low_side_gate, 1'h0);
    valley_below_neg_hi <= 1'h0;
    w(8);
    chk("ls", low_side_gate, 1'h0);
    valley_below_neg_lo <= 1'h0;
    w(8);
    chk("ls", low_side_gate, 1'h1);
    valley_below_neg_hi <= 1'h1;
    valley_below_neg_lo <= 1'h1;
    w(8);
    chk("ls", low_side_gate, 1'h1);
    w(30);
    chk("ls", low_side_gate, 1'h0);
    valley_below_neg_hi <= 1'h0;
    valley_below_neg_lo <= 1'h0;
    w(8);
    chk("ls", low_side_gate, 1'h1);
    $display("negative current test done");
  endtask

  task automatic t_hsd();
    w(8);
    switch_node_high <= 1'h1;
    w(30);
    chk("hsd", high_side_short_detect, 1'h1);
    chk("flag", fault_temp_flag_out, psp_pkg::PSP_FLAG_HIGH);
    duty_hi <= 1'h1;
    switch_node_high <= 1'h0;
    w(10);
    chk("hs_ls", {high_side_gate, low_side_gate}, 2'h1);
    chk("hsd", high_side_short_detect, 1'h1);
    driver_supply_undervolt <= 1'h1;
    driver_supply_above_hi <= 1'h0;
    w(8);
    chk("hsd", high_side_short_detect, 1'h0);
    chk("flag", fault_temp_flag_out, psp_pkg::PSP_FLAG_LOW);
    $display("short test done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    w(5);
    rstn <= 1'h1;
    w(2);
    t_lockout();
    t_pwm();
    t_output_preovervolt_protect();
    t_otp();
    t_oc();
    t_zcd();
    t_ncp();
    t_hsd();
    wrap_up();
  end

  initial
  begin
    #20000;
    error_cnt++;
    wrap_up();
  end
endmodule

bind psp_protect psp_chk u_chk (.*);
